// ===== rtl/fbcp_blk_dec.sv
// maps a table space address to its protection block
`include "fbcp_map.svh"
module fbcp_blk_dec (
  input  wire logic [21:0]         addr,     // address to decode
  input  wire logic [1:0]          boot_sel, // boot size field
  input  wire fbcp_pkg::fbcp_size_t size,    // memory size variant
  output logic      [3:0]          blk,      // block, 8 is boot
  output logic                     impl      // inside implemented flash
);

  // ***********************************************************
  // decode
  // ***********************************************************
  function automatic logic [21:0] boot_end(input logic [1:0] sel);
    if (sel == 2'h0) begin
      boot_end = `FBCP_BOOT_END_2K;
    end else if (sel == 2'h1) begin
      boot_end = `FBCP_BOOT_END_4K;
    end else begin
      boot_end = `FBCP_BOOT_END_8K;
    end
  endfunction

  function automatic logic [21:0] size_top(input fbcp_pkg::fbcp_size_t s);
    case (s)
      fbcp_pkg::SZ_48K: size_top = `FBCP_SIZE_48K;
      fbcp_pkg::SZ_64K: size_top = `FBCP_SIZE_64K;
      fbcp_pkg::SZ_96K: size_top = `FBCP_SIZE_96K;
      default:          size_top = `FBCP_SIZE_128K;
    endcase
  endfunction

  // boot range first so each address lands in one block
  always_comb begin
    if (addr <= boot_end(boot_sel)) begin
      blk = `FBCP_BOOT_BLK;
    end else begin
      blk = {1'b0, addr[16:14]};
    end
    impl = (addr < size_top(size));
  end

endmodule

// ===== rtl/fbcp_cfg_mem.sv
// protection bytes, set to 8'hFF by reset, with clear-only writes and erase
`include "fbcp_map.svh"
module fbcp_cfg_mem (
  input  wire logic                 core_clk,  // core clock
  input  wire logic                 rst,       // sync reset
  input  wire logic [2:0]           rd_idx,    // read index
  input  wire logic                 wr_en,     // write strobe
  input  wire logic [2:0]           wr_idx,    // write index
  input  wire logic [7:0]           wr_data,   // zeros clear bits
  input  wire logic                 erase_all, // chip erase
  input  wire logic                 erase_blk, // block erase
  input  wire logic [3:0]           erase_num, // block to erase
  output logic      [7:0]           rd_data,   // registered read
  output fbcp_pkg::fbcp_locks_t     locks      // decoded lock bits
);

  fbcp_pkg::fbcp_cfg_st_t st_r;
  fbcp_pkg::fbcp_cfg_st_t st_nxt;

  // ***********************************************************
  // store update
  // ***********************************************************
  always_comb begin
    st_nxt = st_r;
    st_nxt.rdata = st_r.bytes[rd_idx];
    if (wr_en) begin
      st_nxt.bytes[wr_idx] = st_r.bytes[wr_idx] & wr_data;
    end
    if (erase_blk && erase_num == `FBCP_BOOT_BLK) begin
      st_nxt.bytes[`FBCP_IDX_CP_HI][`FBCP_BOOT_BIT] = 1'b1;
      st_nxt.bytes[`FBCP_IDX_WR_HI][`FBCP_BOOT_BIT] = 1'b1;
      st_nxt.bytes[`FBCP_IDX_FRD_HI][`FBCP_BOOT_BIT] = 1'b1;
    end else if (erase_blk) begin
      st_nxt.bytes[`FBCP_IDX_CP_LO][erase_num[2:0]] = 1'b1;
      st_nxt.bytes[`FBCP_IDX_WR_LO][erase_num[2:0]] = 1'b1;
      st_nxt.bytes[`FBCP_IDX_FRD_LO][erase_num[2:0]] = 1'b1;
    end
    if (erase_all) begin
      for (int i = 0; i < 8; i++) begin
        st_nxt.bytes[i] = `FBCP_CFG_RST;
      end
    end
  end

  // state register
  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_r <= {{8{`FBCP_CFG_RST}}, 8'h00};
    end else begin
      st_r <= st_nxt;
    end
  end

  // ***********************************************************
  // lock decode
  // ***********************************************************
  assign rd_data = st_r.rdata;
  assign locks.ext = {st_r.bytes[`FBCP_IDX_CP_HI][`FBCP_BOOT_BIT],
                      st_r.bytes[`FBCP_IDX_CP_LO]};
  assign locks.wr = {st_r.bytes[`FBCP_IDX_WR_HI][`FBCP_BOOT_BIT],
                     st_r.bytes[`FBCP_IDX_WR_LO]};
  assign locks.frd = {st_r.bytes[`FBCP_IDX_FRD_HI][`FBCP_BOOT_BIT],
                      st_r.bytes[`FBCP_IDX_FRD_LO]};
  assign locks.ee_ext = st_r.bytes[`FBCP_IDX_CP_HI][`FBCP_EE_BIT];
  assign locks.ee_wr = st_r.bytes[`FBCP_IDX_WR_HI][`FBCP_EE_BIT];
  assign locks.cfg_wr = st_r.bytes[`FBCP_IDX_WR_HI][`FBCP_CFGW_BIT];
  assign locks.boot_sel =
    st_r.bytes[`FBCP_IDX_BOOT_SIZE][`FBCP_BSIZE_LSB +: 2];

endmodule

// ===== rtl/fbcp_guard.sv
`include "fbcp_map.svh"
module fbcp_guard #(
  parameter logic [7:0] DEVID_LO = 8'h5A, // arbitrary value
  parameter logic [7:0] DEVID_HI = 8'hA5  // arbitrary value
) (
  input  wire logic                 core_clk, // core clock
  input  wire logic                 rst,      // sync reset
  input  wire fbcp_pkg::fbcp_size_t mem_size, // size variant
  input  wire fbcp_pkg::fbcp_req_t  req,      // table or programmer request
  output logic                      req_ready,// request can be taken
  input  wire logic [21:0]          pc_addr,  // executing address
  output fbcp_pkg::fbcp_rsp_t       rsp,      // answer, data is table latch
  output fbcp_pkg::fbcp_mem_t       mem,      // flash and eeprom strobes
  input  wire logic [7:0]           mem_rdata,// flash data while rd high
  input  wire logic [7:0]           ee_rdata  // eeprom data while ee_rd high
);

  // ***********************************************************
  // declarations
  // ***********************************************************
  fbcp_pkg::fbcp_st_t    st_r;
  fbcp_pkg::fbcp_st_t    st_nxt;
  fbcp_pkg::fbcp_locks_t lk;
  logic [3:0]            tp_blk;
  logic                  tp_impl;
  logic [3:0]            pc_blk;
  logic                  pc_impl;
  logic [7:0]            cfg_rdata;
  logic                  cfg_we;
  logic [7:0]            cfg_wdata;
  logic                  er_all;
  logic                  er_blk;
  logic [2:0]            cfg_idx;
  logic                  is_cfg;
  logic                  is_flash;
  logic                  is_id;
  logic                  is_devid;
  logic                  same_blk;
  logic                  fl_rd_ok;
  logic                  fl_wr_ok;
  logic                  cfg_wr_ok;

  // maps a configuration address onto a store index
  function automatic logic [3:0] cfg_map(input logic [21:0] a);
    if (a == `FBCP_BOOT_SIZE_CFG_ADDR) begin
      cfg_map = {1'b1, `FBCP_IDX_BOOT_SIZE};
    end else if (a == `FBCP_BLK_RW_LOCK_LO_ADDR) begin
      cfg_map = {1'b1, `FBCP_IDX_CP_LO};
    end else if (a == `FBCP_BOOT_EE_LOCK_ADDR) begin
      cfg_map = {1'b1, `FBCP_IDX_CP_HI};
    end else if (a == `FBCP_BLK_WR_LOCK_LO_ADDR) begin
      cfg_map = {1'b1, `FBCP_IDX_WR_LO};
    end else if (a == `FBCP_BOOT_EE_CFG_WR_ADDR) begin
      cfg_map = {1'b1, `FBCP_IDX_WR_HI};
    end else if (a == `FBCP_BLK_FRD_LOCK_LO_ADDR) begin
      cfg_map = {1'b1, `FBCP_IDX_FRD_LO};
    end else if (a == `FBCP_BOOT_FRD_LOCK_ADDR) begin
      cfg_map = {1'b1, `FBCP_IDX_FRD_HI};
    end else begin
      cfg_map = 4'h0;
    end
  endfunction

  // ***********************************************************
  // block decoders for the pointer and the program counter
  // ***********************************************************
  fbcp_blk_dec u_tp_dec (
    .addr     (req.addr),
    .boot_sel (lk.boot_sel),
    .size     (mem_size),
    .blk      (tp_blk),
    .impl     (tp_impl)
  );

  fbcp_blk_dec u_pc_dec (
    .addr     (pc_addr),
    .boot_sel (lk.boot_sel),
    .size     (mem_size),
    .blk      (pc_blk),
    .impl     (pc_impl)
  );

  // ***********************************************************
  // protection bit store
  // ***********************************************************
  fbcp_cfg_mem u_cfg (
    .core_clk  (core_clk),
    .rst       (rst),
    .rd_idx    (cfg_idx),
    .wr_en     (cfg_we),
    .wr_idx    (cfg_idx),
    .wr_data   (cfg_wdata),
    .erase_all (er_all),
    .erase_blk (er_blk),
    .erase_num (tp_blk),
    .rd_data   (cfg_rdata),
    .locks     (lk)
  );

  // ***********************************************************
  // access decisions
  // ***********************************************************
  assign {is_cfg, cfg_idx} = cfg_map(req.addr);
  assign is_flash = (req.addr < `FBCP_FLASH_TOP) && tp_impl;
  assign is_id = (req.addr >= `FBCP_ID_FIRST) && (req.addr <= `FBCP_ID_LAST);
  assign is_devid = (req.addr == `FBCP_DEVID_LO) || (req.addr == `FBCP_DEVID_HI);
  assign same_blk = pc_impl && (pc_blk == tp_blk);

  // external lock only matters to the programmer
  assign fl_rd_ok = req.from_pgm ? lk.ext[tp_blk]
                                 : (lk.frd[tp_blk] || same_blk);
  assign fl_wr_ok = req.from_pgm ? lk.ext[tp_blk]
                                 : lk.wr[tp_blk];
  assign cfg_wr_ok = req.from_pgm || lk.cfg_wr;

  // the CPU can never clear the configuration write lock itself
  always_comb begin
    cfg_wdata = req.wdata;
    if (!req.from_pgm && cfg_idx == `FBCP_IDX_WR_HI) begin
      cfg_wdata[`FBCP_CFGW_BIT] = 1'b1;
    end
  end

  // ***********************************************************
  // request controller
  // ***********************************************************
  always_comb begin
    st_nxt = st_r;
    st_nxt.rsp.done = 1'b0;
    st_nxt.mem.rd = 1'b0;
    st_nxt.mem.wr = 1'b0;
    st_nxt.mem.ee_rd = 1'b0;
    st_nxt.mem.ee_wr = 1'b0;
    cfg_we = 1'b0;
    er_all = 1'b0;
    er_blk = 1'b0;
    case (st_r.state)
      fbcp_pkg::ST_IDLE: begin
        if (req.valid) begin
          st_nxt.state = fbcp_pkg::ST_WAIT;
          st_nxt.mem.addr = req.addr;
          st_nxt.mem.wdata = req.wdata;
          st_nxt.src = fbcp_pkg::SRC_HOLD;
          st_nxt.ok = 1'b0;
          st_nxt.rsp.data = st_r.rsp.data;
          case (req.op)
            fbcp_pkg::OP_TBL_RD: begin
              st_nxt.rsp.data = 8'h00;
              if ((is_flash && fl_rd_ok) || is_id) begin
                st_nxt.mem.rd = 1'b1;
                st_nxt.src = fbcp_pkg::SRC_MEM;
                st_nxt.ok = 1'b1;
              end else if (is_cfg) begin
                st_nxt.src = fbcp_pkg::SRC_CFG;
                st_nxt.ok = 1'b1;
              end else if (is_devid) begin
                st_nxt.rsp.data = req.addr[0] ? DEVID_HI : DEVID_LO;
                st_nxt.ok = 1'b1;
              end
            end
            fbcp_pkg::OP_TBL_WR: begin
              if ((is_flash && fl_wr_ok) || is_id) begin
                st_nxt.mem.wr = 1'b1;
                st_nxt.ok = 1'b1;
              end else if (is_cfg && cfg_wr_ok) begin
                cfg_we = 1'b1;
                st_nxt.ok = 1'b1;
              end
            end
            fbcp_pkg::OP_EE_RD: begin
              if (!req.from_pgm || lk.ee_ext) begin
                st_nxt.mem.ee_rd = 1'b1;
                st_nxt.src = fbcp_pkg::SRC_EE;
                st_nxt.ok = 1'b1;
              end
            end
            fbcp_pkg::OP_EE_WR: begin
              if (lk.ee_wr && (!req.from_pgm || lk.ee_ext)) begin
                st_nxt.mem.ee_wr = 1'b1;
                st_nxt.ok = 1'b1;
              end
            end
            fbcp_pkg::OP_BLK_ERASE: begin
              if (req.from_pgm && is_flash) begin
                er_blk = 1'b1;
                st_nxt.ok = 1'b1;
              end
            end
            fbcp_pkg::OP_CHIP_ERASE: begin
              if (req.from_pgm) begin
                er_all = 1'b1;
                st_nxt.ok = 1'b1;
              end
            end
            default: begin
              st_nxt.ok = 1'b0;
            end
          endcase
        end
      end
      fbcp_pkg::ST_WAIT: begin
        st_nxt.state = fbcp_pkg::ST_IDLE;
        st_nxt.rsp.done = 1'b1;
        st_nxt.rsp.ok = st_r.ok;
        case (st_r.src)
          fbcp_pkg::SRC_MEM: st_nxt.rsp.data = mem_rdata;
          fbcp_pkg::SRC_EE:  st_nxt.rsp.data = ee_rdata;
          fbcp_pkg::SRC_CFG: st_nxt.rsp.data = cfg_rdata;
          default:           st_nxt.rsp.data = st_r.rsp.data;
        endcase
      end
      default: begin
        st_nxt.state = fbcp_pkg::ST_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_r <= '0;
      st_r.state <= fbcp_pkg::ST_IDLE;
      st_r.src <= fbcp_pkg::SRC_HOLD;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ***********************************************************
  // outputs
  // ***********************************************************
  assign req_ready = (st_r.state == fbcp_pkg::ST_IDLE);
  assign rsp = st_r.rsp;
  assign mem = st_r.mem;

endmodule

// ===== rtl/fbcp_map.svh
// address map, field positions and reset values of the protection block
`ifndef FBCP_MAP_SVH
`define FBCP_MAP_SVH

// ***********************************************************
// table space regions
// ***********************************************************
`define FBCP_FLASH_TOP   22'h200000
`define FBCP_ID_FIRST    22'h200000
`define FBCP_ID_LAST     22'h200007
`define FBCP_DEVID_LO    22'h3FFFFE
`define FBCP_DEVID_HI    22'h3FFFFF
`define FBCP_CFG_PAGE    22'h300000

// ***********************************************************
// configuration byte offsets
// ***********************************************************
`define FBCP_BOOT_SIZE_CFG_ADDR     22'h300006
`define FBCP_BLK_RW_LOCK_LO_ADDR    22'h300008
`define FBCP_BOOT_EE_LOCK_ADDR      22'h300009
`define FBCP_BLK_WR_LOCK_LO_ADDR    22'h30000A
`define FBCP_BOOT_EE_CFG_WR_ADDR    22'h30000B
`define FBCP_BLK_FRD_LOCK_LO_ADDR   22'h30000C
`define FBCP_BOOT_FRD_LOCK_ADDR     22'h30000D

// ***********************************************************
// configuration store indices
// ***********************************************************
`define FBCP_IDX_BOOT_SIZE  3'h0
`define FBCP_IDX_CP_LO      3'h2
`define FBCP_IDX_CP_HI      3'h3
`define FBCP_IDX_WR_LO      3'h4
`define FBCP_IDX_WR_HI      3'h5
`define FBCP_IDX_FRD_LO     3'h6
`define FBCP_IDX_FRD_HI     3'h7

// ***********************************************************
// field positions and reset values
// ***********************************************************
`define FBCP_BOOT_BIT       6
`define FBCP_EE_BIT         7
`define FBCP_CFGW_BIT       5
`define FBCP_BSIZE_LSB      4
`define FBCP_BOOT_BLK       4'h8
`define FBCP_CFG_RST        8'hFF

// ***********************************************************
// flash boundaries
// ***********************************************************
`define FBCP_BOOT_END_2K    22'h0007FF
`define FBCP_BOOT_END_4K    22'h000FFF
`define FBCP_BOOT_END_8K    22'h001FFF
`define FBCP_BLK0_END       22'h003FFF
`define FBCP_SIZE_48K       22'h00C000
`define FBCP_SIZE_64K       22'h010000
`define FBCP_SIZE_96K       22'h018000
`define FBCP_SIZE_128K      22'h020000

`endif

// ===== rtl/fbcp_pkg.sv
// types shared by the flash block protection logic
package fbcp_pkg;

  // memory size variant
  typedef enum logic [1:0] {
    SZ_48K  = 2'h0,
    SZ_64K  = 2'h1,
    SZ_96K  = 2'h2,
    SZ_128K = 2'h3
  } fbcp_size_t;

  // request kinds
  typedef enum logic [2:0] {
    OP_TBL_RD     = 3'h0,
    OP_TBL_WR     = 3'h1,
    OP_EE_RD      = 3'h2,
    OP_EE_WR      = 3'h3,
    OP_BLK_ERASE  = 3'h4,
    OP_CHIP_ERASE = 3'h5
  } fbcp_op_t;

  // controller states, one-hot
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_WAIT = 2'b10
  } fbcp_state_t;

  // where the answer byte comes from
  typedef enum logic [1:0] {
    SRC_HOLD = 2'h0,
    SRC_MEM  = 2'h1,
    SRC_EE   = 2'h2,
    SRC_CFG  = 2'h3
  } fbcp_src_t;

  typedef struct packed {
    logic        valid;
    logic        from_pgm;
    fbcp_op_t    op;
    logic [21:0] addr;
    logic [7:0]  wdata;
  } fbcp_req_t;

  typedef struct packed {
    logic       done;
    logic       ok;
    logic [7:0] data;
  } fbcp_rsp_t;

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic        ee_rd;
    logic        ee_wr;
    logic [21:0] addr;
    logic [7:0]  wdata;
  } fbcp_mem_t;

  // lock vectors, index 8 is the boot block; 1 means unlocked
  typedef struct packed {
    logic [8:0] ext;
    logic [8:0] wr;
    logic [8:0] frd;
    logic       ee_ext;
    logic       ee_wr;
    logic       cfg_wr;
    logic [1:0] boot_sel;
  } fbcp_locks_t;

  typedef struct packed {
    logic [7:0][7:0] bytes;
    logic [7:0]      rdata;
  } fbcp_cfg_st_t;

  typedef struct packed {
    fbcp_state_t state;
    fbcp_src_t   src;
    logic        ok;
    fbcp_rsp_t   rsp;
    fbcp_mem_t   mem;
  } fbcp_st_t;

endpackage

// ===== test/fbcp_guard_properties.sv
// timing and access checks on the guard's ports
module fbcp_guard_properties #(
  parameter logic [7:0] DEVID_LO = 8'h5A, // arbitrary value
  parameter logic [7:0] DEVID_HI = 8'hA5  // arbitrary value
) (
  input wire logic                 core_clk,  // core clock
  input wire logic                 rst,       // sync reset
  input wire fbcp_pkg::fbcp_size_t mem_size,  // size variant
  input wire fbcp_pkg::fbcp_req_t  req,       // request
  input wire logic                 req_ready, // request can be taken
  input wire logic [21:0]          pc_addr,   // executing address
  input wire fbcp_pkg::fbcp_rsp_t  rsp,       // answer
  input wire fbcp_pkg::fbcp_mem_t  mem,       // memory strobes
  input wire logic [7:0]           mem_rdata, // flash data
  input wire logic [7:0]           ee_rdata   // eeprom data
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // ***********************************************************
  // request sequences
  // ***********************************************************
  sequence s_take;
    req.valid && req_ready;
  endsequence
  sequence s_rd_take;
    s_take ##0 req.op == fbcp_pkg::OP_TBL_RD;
  endsequence
  sequence s_answer;
    !rsp.done ##1 rsp.done;
  endsequence
  // ***********************************************************
  // properties
  // ***********************************************************
  chk_busy_refuse: assert property (s_take |=> !req_ready ##1 req_ready)
    else $error("ready not dropped for one cycle");
  chk_done_timing: assert property (s_take |=> s_answer)
    else $error("answer not two cycles after take");
  chk_read_latch: assert property (mem.rd |=> rsp.ok && rsp.data == $past(mem_rdata))
    else $error("read byte not latched");
  chk_write_grant: assert property (mem.wr |=> rsp.done && rsp.ok)
    else $error("write strobe without grant");
  chk_ee_write: assert property (mem.ee_wr |=> rsp.done && rsp.ok)
    else $error("eeprom write strobe without grant");
  chk_wr_carry: assert property (s_take ##0 req.op == fbcp_pkg::OP_TBL_WR
      |=> mem.addr == $past(req.addr) && mem.wdata == $past(req.wdata))
    else $error("write address or data not carried");
  chk_cpu_erase: assert property (s_take ##0 (!req.from_pgm
      && req.op inside {fbcp_pkg::OP_BLK_ERASE, fbcp_pkg::OP_CHIP_ERASE})
      |=> !mem.wr ##1 (rsp.done && !rsp.ok))
    else $error("cpu erase granted");
  chk_unimpl_zero: assert property (s_rd_take ##0 (mem_size == fbcp_pkg::SZ_48K
      && req.addr >= 22'h00C000 && req.addr < 22'h200000)
      |=> !mem.rd ##1 (!rsp.ok && rsp.data == 8'h00))
    else $error("unimplemented read not zero");
  chk_cpu_ee_read: assert property (s_take ##0 (!req.from_pgm
      && req.op == fbcp_pkg::OP_EE_RD) |=> mem.ee_rd ##1 rsp.ok)
    else $error("cpu eeprom read refused");
  chk_id_open: assert property (s_rd_take ##0 req.addr[21:3] == 19'h40000
      |=> mem.rd ##1 rsp.ok)
    else $error("id location not readable");
  chk_devid_read: assert property (s_rd_take ##0 req.addr == 22'h3FFFFF
      |-> ##2 rsp.ok && rsp.data == DEVID_HI)
    else $error("device id byte wrong");
endmodule

bind fbcp_guard fbcp_guard_properties #(.DEVID_LO(DEVID_LO), .DEVID_HI(DEVID_HI)) u_props (
  .core_clk(core_clk), .rst(rst), .mem_size(mem_size), .req(req), .req_ready(req_ready),
  .pc_addr(pc_addr), .rsp(rsp), .mem(mem), .mem_rdata(mem_rdata), .ee_rdata(ee_rdata));

// ===== test/fbcp_mem_model.sv
// flash and eeprom data model answering the guard's read strobes
module fbcp_mem_model (
  input  wire logic                core_clk,  // core clock
  input  wire fbcp_pkg::fbcp_mem_t mem,       // strobes from the guard
  output logic      [7:0]          mem_rdata, // flash or id byte
  output logic      [7:0]          ee_rdata   // eeprom byte
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] churn_r = 8'h00;
  // filler outside the strobes; ~churn_r + 1 from 8'h00 keeps churn_r at 8'h00
  always @(posedge core_clk) churn_r <= ~churn_r + 8'h01;
  // data only in the strobed cycle
  assign mem_rdata = mem.rd ? (mem.addr[7:0] ^ 8'hC3) : churn_r;
  assign ee_rdata  = mem.ee_rd ? (mem.addr[7:0] ^ 8'h5A) : ~churn_r;
endmodule

// ===== test/tb_top.sv
// self-checking bench for the flash block protection guard
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] ID_LO = 8'h3C; // arbitrary value
  localparam logic [7:0] ID_HI = 8'hC5; // arbitrary value
  typedef struct packed {
    logic       ok;
    logic [7:0] dat;
    logic       chk;
  } fbcp_tb_exp_t;
  logic                 core_clk = 1'b0;
  logic                 rst = 1'b1;
  fbcp_pkg::fbcp_size_t mem_size = fbcp_pkg::SZ_128K;
  fbcp_pkg::fbcp_req_t  req = '0;
  logic [21:0]          pc_addr = 22'h000000;
  logic                 req_ready;
  fbcp_pkg::fbcp_rsp_t  rsp;
  fbcp_pkg::fbcp_mem_t  mem;
  logic [7:0]           mem_rdata;
  logic [7:0]           ee_rdata;
  logic [21:0]          tops [4] = '{22'h00C000, 22'h010000, 22'h018000, 22'h020000};
  fbcp_tb_exp_t         q [$];
  int                   fails = 0;
  int                   n_compared = 0;
  integer               seed = 32'hb9d6;
  logic [21:0]          a;

  always #5 core_clk = ~core_clk;

  fbcp_guard #(.DEVID_LO(ID_LO), .DEVID_HI(ID_HI)) dut (.core_clk(core_clk), .rst(rst),
    .mem_size(mem_size), .req(req), .req_ready(req_ready), .pc_addr(pc_addr), .rsp(rsp),
    .mem(mem), .mem_rdata(mem_rdata), .ee_rdata(ee_rdata));
  fbcp_mem_model u_model (.core_clk(core_clk), .mem(mem), .mem_rdata(mem_rdata),
    .ee_rdata(ee_rdata));

  // ***********************************************************
  // checking
  // ***********************************************************
  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic cmp_rsp(fbcp_tb_exp_t e);
    n_compared++;
    if (rsp.ok !== e.ok || (e.chk && rsp.data !== e.dat)) begin
      fails++;
      $display("MISMATCH %0t ok %b data %h want %b %h", $time, rsp.ok, rsp.data, e.ok, e.dat);
    end
  endtask

  // watcher takes the oldest note per answer
  always @(negedge core_clk) if (rsp.done === 1'b1) begin
    if (q.size() == 0) begin
      fails++;
      $display("MISMATCH %0t unexpected answer", $time);
    end else cmp_rsp(q.pop_front());
  end

  // ***********************************************************
  // stimulus
  // ***********************************************************
  task automatic rq(logic pgm, fbcp_pkg::fbcp_op_t op, logic [21:0] ad, logic [7:0] wd,
                    logic [21:0] pc, logic ok, logic [7:0] d, logic chk);
    int n;
    @(posedge core_clk);
    req <= '{1'b1, pgm, op, ad, wd};
    pc_addr <= pc;
    for (n = 0; n < 20; n++) begin
      @(negedge core_clk);
      if (req_ready === 1'b1) break;
    end
    if (n == 20) begin
      fails++;
      $display("MISMATCH %0t request not taken", $time);
      final_report();
    end
    @(posedge core_clk);
    q.push_back('{ok, d, chk});
    req.valid <= 1'b0;
  endtask

  task automatic rd(logic pgm, logic [21:0] ad, logic [21:0] pc, logic ok, logic [7:0] d);
    rq(pgm, fbcp_pkg::OP_TBL_RD, ad, 8'h00, pc, ok, d, 1'b1);
  endtask

  task automatic wr(logic pgm, logic [21:0] ad, logic [7:0] wd, logic ok);
    rq(pgm, fbcp_pkg::OP_TBL_WR, ad, wd, 22'h000000, ok, 8'h00, 1'b0);
  endtask

  function automatic logic [7:0] fd(logic [21:0] ad);
    return ad[7:0] ^ 8'hC3;
  endfunction

  // random offset inside a 16-Kbyte block
  function automatic logic [21:0] ra(logic [21:0] b);
    logic [31:0] r;
    r = $random(seed);
    return b | {8'h00, r[13:0]};
  endfunction

  // main sequence
  initial begin
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    for (int s = 0; s < 4; s++) begin
      mem_size <= fbcp_pkg::fbcp_size_t'(s);
      rd(0, tops[s] - 22'h1, tops[s] - 22'h1, 1, fd(tops[s] - 22'h1));
      rd(0, tops[s], 22'h000000, 0, 8'h00);
    end
    for (int i = 8; i < 14; i++) rd(0, 22'h300000 + 22'(i), 22'h0, 1, 8'hFF);
    rd(0, 22'h30000E, 22'h0, 0, 8'h00);
    wr(0, 22'h30000D, 8'hBF, 1);
    wr(0, 22'h30000D, 8'hFF, 1);
    rd(0, 22'h30000D, 22'h0, 1, 8'hBF);
    rd(0, 22'h001FFF, 22'h004000, 0, 8'h00);
    rd(0, 22'h001FFF, 22'h000100, 1, fd(22'h001FFF));
    rd(0, 22'h002000, 22'h004000, 1, fd(22'h002000));
    wr(0, 22'h300006, 8'hDF, 1);
    rd(0, 22'h000FFF, 22'h004000, 0, 8'h00);
    rd(0, 22'h001000, 22'h004000, 1, fd(22'h001000));
    wr(0, 22'h300006, 8'hCF, 1);
    rd(0, 22'h0007FF, 22'h003000, 0, 8'h00);
    rd(0, 22'h000800, 22'h004000, 1, fd(22'h000800));
    rd(0, 22'h300006, 22'h0, 1, 8'hCF);
    wr(0, 22'h30000A, 8'hF7, 1);
    a = ra(22'h00C000);
    wr(0, a, 8'h55, 0);
    wr(1, a, 8'h55, 1);
    wr(0, ra(22'h008000), 8'h55, 1);
    wr(0, 22'h300008, 8'hFD, 1);
    a = ra(22'h004000);
    rd(1, a, 22'h0, 0, 8'h00);
    wr(1, a, 8'hAA, 0);
    rd(0, a, 22'h010000, 1, fd(a));
    rq(0, fbcp_pkg::OP_BLK_ERASE, a, 8'h00, 22'h0, 0, 8'h00, 1'b0);
    rq(1, fbcp_pkg::OP_BLK_ERASE, a, 8'h00, 22'h0, 1, 8'h00, 1'b0);
    rd(1, a, 22'h0, 1, fd(a));
    rd(0, 22'h30000A, 22'h0, 1, 8'hF7);
    rq(0, fbcp_pkg::OP_CHIP_ERASE, 22'h0, 8'h00, 22'h0, 0, 8'h00, 1'b0);
    rq(1, fbcp_pkg::OP_CHIP_ERASE, 22'h0, 8'h00, 22'h0, 1, 8'h00, 1'b0);
    rd(0, 22'h30000A, 22'h0, 1, 8'hFF);
    wr(0, 22'h300009, 8'h7F, 1);
    a = ra(22'h000000) & 22'h0003FF;
    // a refused eeprom read keeps the latch, so only the grant is compared
    rq(1, fbcp_pkg::OP_EE_RD, a, 8'h00, 22'h0, 0, 8'h00, 1'b0);
    rq(0, fbcp_pkg::OP_EE_RD, a, 8'h00, 22'h0, 1, a[7:0] ^ 8'h5A, 1'b1);
    rq(1, fbcp_pkg::OP_EE_WR, a, 8'h11, 22'h0, 0, 8'h00, 1'b0);
    rq(0, fbcp_pkg::OP_EE_WR, a, 8'h11, 22'h0, 1, 8'h00, 1'b0);
    wr(0, 22'h30000B, 8'h5F, 1);
    rd(0, 22'h30000B, 22'h0, 1, 8'h7F);
    rq(0, fbcp_pkg::OP_EE_WR, a, 8'h22, 22'h0, 0, 8'h00, 1'b0);
    rq(0, fbcp_pkg::OP_EE_RD, a, 8'h00, 22'h0, 1, a[7:0] ^ 8'h5A, 1'b1);
    wr(1, 22'h30000B, 8'hDF, 1);
    wr(0, 22'h300008, 8'hFE, 0);
    rd(0, 22'h300008, 22'h0, 1, 8'hFF);
    mem_size <= fbcp_pkg::SZ_48K;
    wr(1, 22'h30000C, 8'hF8, 1);
    wr(1, 22'h30000D, 8'hBF, 1);
    wr(1, 22'h300008, 8'hF8, 1);
    rd(0, ra(22'h008000), 22'h004000, 0, 8'h00);
    rd(0, 22'h000100, 22'h004000, 0, 8'h00);
    rd(0, 22'h200003, 22'h001000, 1, fd(22'h200003));
    rd(1, 22'h200007, 22'h0, 1, fd(22'h200007));
    rd(0, 22'h3FFFFE, 22'h0, 1, ID_LO);
    rd(0, 22'h3FFFFF, 22'h0, 1, ID_HI);
    wr(0, 22'h3FFFFE, 8'h00, 0);
    repeat (4) @(posedge core_clk);
    if (q.size() != 0) begin
      fails++;
      $display("MISMATCH %0t answers missing", $time);
    end
    final_report();
  end
endmodule
